// ===== hdl/apcg_pkg.sv
package apcg_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam longint CLK_HZ       = 20_000_000;
  localparam longint LOCK_FCK_MS  = 160;
  localparam longint LOCK_BCK_MS  = 2;
  localparam longint LOCK_MCK_MS  = 40;
  localparam longint LOCK_FCK_CYC = LOCK_FCK_MS * CLK_HZ / 1000;
  localparam longint LOCK_BCK_CYC = LOCK_BCK_MS * CLK_HZ / 1000;
  localparam longint LOCK_MCK_CYC = LOCK_MCK_MS * CLK_HZ / 1000;
  localparam int     CNT_W        = 22;
  localparam int     ACT_W        = 12;
  localparam logic [ACT_W-1:0] ACT_TIMEOUT = 12'hFA0; // no edge for 200us
  localparam logic [CNT_W-1:0] CNT_ZERO = 22'h000000;

  // ----------------------------------------
  // phase accumulator taps (top bit = 1fs)
  // ----------------------------------------
  localparam int TAP_FS    = 31;
  localparam int TAP_16FS  = 27;
  localparam int TAP_32FS  = 26;
  localparam int TAP_64FS  = 25;
  localparam int TAP_256FS = 23;

  // ----------------------------------------
  // field codes
  // ----------------------------------------
  localparam logic [3:0] REF_FCK  = 4'h0;
  localparam logic [3:0] REF_B16  = 4'h1;
  localparam logic [3:0] REF_B32  = 4'h2;
  localparam logic [3:0] REF_B64  = 4'h3;
  localparam logic [1:0] BCK_16FS = 2'h0;
  localparam logic [1:0] BCK_32FS = 2'h1;
  localparam logic [1:0] BCK_64FS = 2'h2;
  localparam logic [1:0] FMT_DSP  = 2'h0;

  typedef enum logic [1:0] {
    APCG_OFF,
    APCG_ACQ,
    APCG_LOCK
  } apcg_state_t;

  // software control word
  typedef struct packed {
    logic       pll_power_enable;
    logic       master_mode;
    logic       mclk_out_enable;
    logic       mclk_pulldown_enable;
    logic [3:0] pll_reference_select;
    logic [3:0] sample_rate_select;
    logic [1:0] bit_clock_rate_select;
    logic [1:0] format_select;
    logic       adc_power_enable;
    logic       dac_power_enable;
    logic       dac_line_path_enable;
    logic       dac_mono_path_enable;
  } apcg_ctrl_t;

  localparam apcg_ctrl_t CTRL_RESET = '{mclk_pulldown_enable: 1'b1, default: '0};

  // sample rate in Hz per reference kind and rate code, 0 when unsupported
  function automatic int apcg_rate_hz(input logic ref_mck, input logic [3:0] code);
    int r;
    r = 0;
    if (ref_mck) begin
      case (code)
        4'h0: r = 8000;
        4'h1: r = 12000;
        4'h2: r = 16000;
        4'h3: r = 24000;
        4'h4: r = 7350;
        4'h5: r = 11025;
        4'h6: r = 14700;
        4'h7: r = 22050;
        4'hA: r = 32000;
        4'hB: r = 48000;
        4'hE: r = 29400;
        4'hF: r = 44100;
        default: r = 0;
      endcase
    end else begin
      case ({code[3], code[1:0]})
        3'h0: r = 8000;
        3'h1: r = 12000;
        3'h2: r = 16000;
        3'h3: r = 24000;
        3'h6: r = 32000;
        3'h7: r = 48000;
        default: r = 0;
      endcase
    end
    return r;
  endfunction

endpackage

// ===== hdl/apcg_clock_gen.sv
`timescale 1ns/1ns
`default_nettype none

module apcg_clock_gen #(
  parameter longint LOCK_FCK_CYC = apcg_pkg::LOCK_FCK_CYC,
  parameter longint LOCK_BCK_CYC = apcg_pkg::LOCK_BCK_CYC,
  parameter longint LOCK_MCK_CYC = apcg_pkg::LOCK_MCK_CYC
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [31:0] prdata,
  // clock pins
  input  wire logic        master_clock_input,
  output logic             master_clock_output,
  output logic             mclk_pulldown_enable,
  input  wire logic        serial_bit_clock_i,
  output logic             serial_bit_clock_o,
  output logic             serial_bit_clock_oe,
  input  wire logic        frame_sync_clock_i,
  output logic             frame_sync_clock_o,
  output logic             frame_sync_clock_oe,
  // status to codec core
  output logic             pll_locked,
  output logic             converter_data_invalid
);

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (LOCK_FCK_CYC < 1 || LOCK_FCK_CYC >= (64'h1 << apcg_pkg::CNT_W)) begin : g_chk_f
    $error("frame lock count out of range");
  end
  if (LOCK_BCK_CYC < 1 || LOCK_BCK_CYC >= (64'h1 << apcg_pkg::CNT_W)) begin : g_chk_b
    $error("bit lock count out of range");
  end
  if (LOCK_MCK_CYC < 1 || LOCK_MCK_CYC >= (64'h1 << apcg_pkg::CNT_W)) begin : g_chk_m
    $error("master lock count out of range");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    apcg_pkg::apcg_ctrl_t            ctrl;
    apcg_pkg::apcg_state_t           st;
    logic [2:0]                      mck_sy;   // sync stages
    logic [2:0]                      bck_sy;
    logic [2:0]                      fck_sy;
    logic [apcg_pkg::ACT_W-1:0]      act_cnt;
    logic [apcg_pkg::CNT_W-1:0]      lock_cnt;
    logic [31:0]                     acc;
    logic                            mclk_o;
    logic                            bclk_o;
    logic                            fclk_o;
    logic                            fmt_error;
    logic [31:0]                     rdata;
  } apcg_regs_t;

  apcg_regs_t r_r;
  apcg_regs_t r_nxt;

  logic                         ref_mck;
  logic                         cfg_valid;
  logic                         ref_edge;
  logic                         ref_active;
  logic [31:0]                  inc;
  logic [apcg_pkg::CNT_W-1:0]   lock_len;
  logic                         ctrl_wr;
  logic                         addr_ok;
  int                           fs_hz;

  // ----------------------------------------
  // configuration decode
  // ----------------------------------------
  always_comb begin
    ref_mck   = r_r.ctrl.pll_reference_select[2];
    fs_hz     = apcg_pkg::apcg_rate_hz(ref_mck, r_r.ctrl.sample_rate_select);
    inc       = 32'((64'(fs_hz) << 32) / apcg_pkg::CLK_HZ);
    cfg_valid = (fs_hz != 0);
    // reference code decode
    case (r_r.ctrl.pll_reference_select)
      4'h0: lock_len = apcg_pkg::CNT_W'(LOCK_FCK_CYC);
      4'h1, 4'h2, 4'h3: lock_len = apcg_pkg::CNT_W'(LOCK_BCK_CYC);
      4'h4, 4'h5, 4'h6, 4'h7, 4'hC, 4'hD: lock_len = apcg_pkg::CNT_W'(LOCK_MCK_CYC);
      default: begin
        lock_len  = apcg_pkg::CNT_ZERO;
        cfg_valid = 1'b0;
      end
    endcase
    if (r_r.ctrl.bit_clock_rate_select == 2'h3 && r_r.ctrl.master_mode) begin
      cfg_valid = 1'b0;
    end
    if (r_r.ctrl.master_mode && !ref_mck) begin
      cfg_valid = 1'b0;
    end
    // edges of the chosen reference, on synchronised copies only
    if (ref_mck) begin
      ref_edge = r_r.mck_sy[1] & ~r_r.mck_sy[2];
    end else if (r_r.ctrl.pll_reference_select == apcg_pkg::REF_FCK) begin
      ref_edge = r_r.fck_sy[1] & ~r_r.fck_sy[2];
    end else begin
      ref_edge = r_r.bck_sy[1] & ~r_r.bck_sy[2];
    end
    ref_active = (r_r.act_cnt != apcg_pkg::ACT_TIMEOUT);
    ctrl_wr    = psel && penable && pwrite && paddr == apcg_pkg::ADDR_CTRL;
    addr_ok    = paddr == apcg_pkg::ADDR_CTRL || paddr == apcg_pkg::ADDR_STATUS;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    r_nxt = r_r;
    // pin synchronisers
    r_nxt.mck_sy = {r_r.mck_sy[1:0], master_clock_input};
    r_nxt.bck_sy = {r_r.bck_sy[1:0], serial_bit_clock_i};
    r_nxt.fck_sy = {r_r.fck_sy[1:0], frame_sync_clock_i};
    // reference activity watchdog
    if (ref_edge) begin
      r_nxt.act_cnt = '0;
    end else if (ref_active) begin
      r_nxt.act_cnt = r_r.act_cnt + apcg_pkg::ACT_W'(1);
    end
    // register writes
    if (ctrl_wr) begin
      r_nxt.ctrl = apcg_pkg::apcg_ctrl_t'(pwdata[$bits(apcg_pkg::apcg_ctrl_t)-1:0]);
    end
    // read data captured in setup phase
    if (psel && !penable) begin
      if (paddr == apcg_pkg::ADDR_CTRL) begin
        r_nxt.rdata = 32'(r_r.ctrl);
      end else if (paddr == apcg_pkg::ADDR_STATUS) begin
        r_nxt.rdata = {27'h0, !ref_active, r_r.fmt_error, !cfg_valid,
                       r_r.st == apcg_pkg::APCG_ACQ, r_r.st == apcg_pkg::APCG_LOCK};
      end else begin
        r_nxt.rdata = 32'h0;
      end
    end
    // lock tracking
    case (r_r.st)
      apcg_pkg::APCG_OFF: begin
        r_nxt.lock_cnt = lock_len;
        if (r_r.ctrl.pll_power_enable) begin
          r_nxt.st = apcg_pkg::APCG_ACQ;
        end
      end
      apcg_pkg::APCG_ACQ: begin
        if (r_r.lock_cnt == apcg_pkg::CNT_ZERO && cfg_valid) begin
          r_nxt.st  = apcg_pkg::APCG_LOCK;
          r_nxt.acc = '0;
        end else if (ref_active && r_r.lock_cnt != apcg_pkg::CNT_ZERO) begin
          r_nxt.lock_cnt = r_r.lock_cnt - apcg_pkg::CNT_W'(1);
        end
      end
      apcg_pkg::APCG_LOCK: begin
        if (!cfg_valid || !ref_active) begin
          r_nxt.st       = apcg_pkg::APCG_ACQ;
          r_nxt.lock_cnt = lock_len;
        end
      end
      default: r_nxt.st = apcg_pkg::APCG_OFF;
    endcase
    // restart acquisition on rate or reference change
    if (ctrl_wr && r_r.st != apcg_pkg::APCG_OFF &&
        (r_nxt.ctrl.sample_rate_select != r_r.ctrl.sample_rate_select ||
         r_nxt.ctrl.pll_reference_select != r_r.ctrl.pll_reference_select)) begin
      r_nxt.st       = apcg_pkg::APCG_ACQ;
      r_nxt.lock_cnt = lock_len;
    end
    if (!r_r.ctrl.pll_power_enable) begin
      r_nxt.st = apcg_pkg::APCG_OFF;
    end
    // phase accumulator produces 1fs..256fs taps
    if (r_r.st != apcg_pkg::APCG_OFF && !(r_r.st == apcg_pkg::APCG_ACQ && r_nxt.st ==
        apcg_pkg::APCG_LOCK)) begin
      r_nxt.acc = r_r.acc + inc;
    end
    // master clock output: low unless enabled
    r_nxt.mclk_o = r_r.ctrl.mclk_out_enable && r_r.st != apcg_pkg::APCG_OFF &&
                   r_r.acc[apcg_pkg::TAP_256FS];
    // bit and frame clocks, low until locked
    if (r_r.st == apcg_pkg::APCG_LOCK && r_r.ctrl.master_mode) begin
      r_nxt.fclk_o = r_r.acc[apcg_pkg::TAP_FS];
      case (r_r.ctrl.bit_clock_rate_select)
        apcg_pkg::BCK_16FS: r_nxt.bclk_o = r_r.acc[apcg_pkg::TAP_16FS];
        apcg_pkg::BCK_32FS: r_nxt.bclk_o = r_r.acc[apcg_pkg::TAP_32FS];
        apcg_pkg::BCK_64FS: r_nxt.bclk_o = r_r.acc[apcg_pkg::TAP_64FS];
        default:            r_nxt.bclk_o = 1'b0;
      endcase
    end else begin
      r_nxt.fclk_o = 1'b0;
      r_nxt.bclk_o = 1'b0;
    end
    // format limit at 16fs bit clock in master mode
    r_nxt.fmt_error = r_r.ctrl.master_mode &&
                      r_r.ctrl.bit_clock_rate_select == apcg_pkg::BCK_16FS &&
                      r_r.ctrl.format_select != apcg_pkg::FMT_DSP;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_r      <= '0;
      r_r.ctrl <= apcg_pkg::CTRL_RESET;
    end else begin
      r_r <= r_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign pready                 = 1'b1;
  assign pslverr                = psel && penable && !addr_ok;
  assign prdata                 = r_r.rdata;
  assign master_clock_output    = r_r.mclk_o;
  assign mclk_pulldown_enable   = r_r.ctrl.mclk_pulldown_enable;
  assign serial_bit_clock_o     = r_r.bclk_o;
  assign frame_sync_clock_o     = r_r.fclk_o;
  assign serial_bit_clock_oe    = r_r.ctrl.master_mode;
  assign frame_sync_clock_oe    = r_r.ctrl.master_mode;
  assign pll_locked             = r_r.st == apcg_pkg::APCG_LOCK;
  assign converter_data_invalid = r_r.ctrl.pll_power_enable && !pll_locked;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_mclk_low_off: assert property (
    !$past(r_r.ctrl.mclk_out_enable) |-> !master_clock_output)
    else $error("master clock output not low while disabled");
  chk_bclk_unlocked: assert property (
    ($past(r_r.st) != apcg_pkg::APCG_LOCK) |-> !serial_bit_clock_o && !frame_sync_clock_o)
    else $error("bit or frame clock active while unlocked");
  chk_lock_on_power: assert property (
    $rose(r_r.ctrl.pll_power_enable) |-> ##1 !pll_locked [*2])
    else $error("locked right after power-up");
  chk_rate_change: assert property (
    ($changed(r_r.ctrl.sample_rate_select) && r_r.ctrl.pll_power_enable) |-> !pll_locked)
    else $error("lock kept across rate change");
  chk_invalid_cfg: assert property (
    (!cfg_valid && r_r.st == apcg_pkg::APCG_LOCK) |=> !pll_locked)
    else $error("lock held with unsupported code");
  chk_fmt_flag: assert property (
    (r_r.ctrl.master_mode && r_r.ctrl.bit_clock_rate_select == apcg_pkg::BCK_16FS &&
     r_r.ctrl.format_select != apcg_pkg::FMT_DSP) |=> r_r.fmt_error)
    else $error("format limit at 16fs not flagged");
  chk_slave_pins: assert property (
    !r_r.ctrl.master_mode |-> !serial_bit_clock_oe && !frame_sync_clock_oe)
    else $error("clock pins driven in slave mode");
  chk_lock_time: assert property (
    $rose(pll_locked) |-> $past(r_r.lock_cnt) == apcg_pkg::CNT_ZERO &&
                          $past(r_r.st) == apcg_pkg::APCG_ACQ)
    else $error("lock before lock time elapsed");
  chk_mute_flag: assert property (
    (r_r.ctrl.pll_power_enable && !pll_locked) |-> converter_data_invalid)
    else $error("invalid data not flagged while unlocked");

endmodule

`default_nettype wire

// ===== verification/apcg_far_end.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// far side clock source
// ----------------------------------------
module apcg_far_end (
  // control from bench
  input  wire logic run,
  // reference and serial clocks
  output logic      master_clock_input,
  output logic      bit_clock_drive,
  output logic      frame_clock_drive
);
  logic [4:0] div_r;
  logic [2:0] bdiv_r;

  // free clocks only while run is high, else lines sit at pull-down level
  // bit clock is master clock / 10 (250kHz), frame is bit / 32: fs about 7.8kHz
  initial begin
    master_clock_input = 1'b0;
    bit_clock_drive    = 1'b0;
    frame_clock_drive  = 1'b0;
    div_r              = 5'h00;
    bdiv_r             = 3'h0;
    #37;
    forever begin
      #200;
      master_clock_input = run ? ~master_clock_input : 1'b0;
      if (run && master_clock_input) begin
        if (bdiv_r == 3'h4) begin
          bdiv_r          = 3'h0;
          bit_clock_drive = ~bit_clock_drive;
          if (bit_clock_drive) begin
            div_r = div_r + 5'h01; // 32 bit clocks a frame, frame high for 16 and low for 16
          end
        end else begin
          bdiv_r = bdiv_r + 3'h1;
        end
      end
      if (!run) begin
        bit_clock_drive = 1'b0;
      end
      frame_clock_drive = run ? div_r[4] : 1'b0;
    end
  end
endmodule

`default_nettype wire

// ===== verification/apcg_clock_gen_tb.sv
`timescale 1ns/1ns
`default_nettype none

module apcg_clock_gen_tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, run;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        mck_in, mck_out, pd_en, bck_o, bck_oe, fck_o, fck_oe, locked, data_bad;
  logic        bck_far, fck_far, bck_w, fck_w, err;
  int          fail_count, total_checks, cyc, mc, bc, fc, n;
  apcg_pkg::apcg_ctrl_t c;

  // pin resolution, released lines follow the far end drive
  assign bck_w = bck_oe ? bck_o : bck_far;
  assign fck_w = fck_oe ? fck_o : fck_far;

  apcg_clock_gen #(.LOCK_FCK_CYC(20), .LOCK_BCK_CYC(20), .LOCK_MCK_CYC(20)) apcg_clock_gen_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .master_clock_input(mck_in), .master_clock_output(mck_out),
    .mclk_pulldown_enable(pd_en), .serial_bit_clock_i(bck_w), .serial_bit_clock_o(bck_o),
    .serial_bit_clock_oe(bck_oe), .frame_sync_clock_i(fck_w), .frame_sync_clock_o(fck_o),
    .frame_sync_clock_oe(fck_oe), .pll_locked(locked), .converter_data_invalid(data_bad));

  apcg_far_end apcg_far_end_i (.run(run), .master_clock_input(mck_in),
    .bit_clock_drive(bck_far), .frame_clock_drive(fck_far));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol);
    total_checks++;
    if ((^got) === 1'bx || got > exp + tol || got + tol < exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer, waits on pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd  = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic set_ctrl();
    apb(1'b1, apcg_pkg::ADDR_CTRL, {12'h000, c});
  endtask

  task automatic wait_lock(output int k);
    k = 0;
    while (locked !== 1'b1 && k < 400) begin
      @(posedge pclk);
      k++;
    end
  endtask

  // rising edges of generated clocks in a window
  task automatic measure(input int len);
    logic pm, pb, pf;
    mc = 0; bc = 0; fc = 0;
    pm = mck_out; pb = bck_w; pf = fck_w;
    repeat (len) begin
      @(posedge pclk);
      #1;
      mc += (mck_out && !pm); bc += (bck_w && !pb); fc += (fck_w && !pf);
      pm = mck_out; pb = bck_w; pf = fck_w;
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk(pd_en, 1'b1, 0);
    chk({bck_oe, fck_oe, locked, mck_out}, 4'h0, 0);
    apb(1'b0, apcg_pkg::ADDR_CTRL, 32'h0);
    chk(rd, {12'h000, apcg_pkg::CTRL_RESET}, 0);
    apb(1'b1, 8'h08, 32'hFFFFFFFF);
    chk(err, 1'b1, 0);
    apb(1'b0, apcg_pkg::ADDR_CTRL, 32'h0);
    chk(rd, {12'h000, apcg_pkg::CTRL_RESET}, 0);
    $display("test reset done");
  endtask

  task automatic t_master();
    c = apcg_pkg::CTRL_RESET;
    c.mclk_pulldown_enable = 1'b0;
    c.pll_power_enable = 1'b1; c.master_mode = 1'b1; c.mclk_out_enable = 1'b1;
    c.pll_reference_select = 4'h4; c.format_select = 2'h1;
    set_ctrl();
    repeat (10) begin
      @(posedge pclk);
      chk({locked, bck_o, fck_o, data_bad}, 4'h1, 0);
    end
    wait_lock(n);
    chk(locked, 1'b1, 0);
    chk(n > 5, 1'b1, 0);
    chk({bck_oe, fck_oe}, 2'h3, 0);
    for (int b = 0; b < 3; b++) begin
      c.bit_clock_rate_select = b[1:0];
      set_ctrl();
      wait_lock(n);
      apb(1'b0, apcg_pkg::ADDR_STATUS, 32'h0);
      chk(rd[3], b == 0, 0);
      chk(rd[0], 1'b1, 0);
      measure(2500);
      measure(2500);
      chk(bc, 16 << b, 1);
      chk(fc, 1, 1);
      chk(mc, 256, 2);
    end
    c.mclk_out_enable = 1'b0;
    set_ctrl();
    measure(2500);
    chk(mc, 0, 0);
    c.sample_rate_select = 4'h1;
    set_ctrl();
    repeat (3) @(posedge pclk);
    chk(locked, 1'b0, 0);
    wait_lock(n);
    chk(locked, 1'b1, 0);
    $display("test master done");
  endtask

  task automatic t_slave();
    c = apcg_pkg::CTRL_RESET;
    c.pll_power_enable = 1'b1; c.mclk_out_enable = 1'b1;
    c.pll_reference_select = 4'h2; c.sample_rate_select = 4'h4;
    set_ctrl();
    @(posedge pclk);
    #1;
    chk({bck_oe, fck_oe, bck_o, fck_o}, 4'h0, 0);
    chk({data_bad, c.dac_line_path_enable, c.dac_mono_path_enable}, 3'h4, 0);
    wait_lock(n);
    chk(locked, 1'b1, 0);
    measure(2500);
    chk(mc, 256, 2);
    run <= 1'b0;
    repeat (4200) @(posedge pclk);
    apb(1'b0, apcg_pkg::ADDR_STATUS, 32'h0);
    chk(rd[4], 1'b1, 0);
    run <= 1'b1;
    $display("test slave done");
  endtask

  task automatic t_invalid();
    for (int k = 0; k < 2; k++) begin
      c = apcg_pkg::CTRL_RESET;
      c.pll_power_enable = 1'b1;
      c.mclk_pulldown_enable = 1'b0;
      c.pll_reference_select = k ? 4'h5 : 4'h8;
      c.sample_rate_select = k ? 4'h8 : 4'h0;
      set_ctrl();
      repeat (300) @(posedge pclk);
      apb(1'b0, apcg_pkg::ADDR_STATUS, 32'h0);
      chk({rd[2], locked}, 2'h2, 0);
    end
    $display("test invalid done");
  endtask

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // clock, timeout and main sequence
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      test_done();
    end
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; run = 1'b1; fail_count = 0; total_checks = 0; cyc = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_master();
    t_slave();
    t_invalid();
    test_done();
  end
endmodule

`default_nettype wire
